// ==== rtl/pmbus_ctrl_consts.svh ====
// constants for the converter management command and protection logic
`ifndef PMBUS_CTRL_CONSTS_SVH
`define PMBUS_CTRL_CONSTS_SVH

// command codes
`define CMD_OPERATION   8'h01
`define CMD_CLEAR_FLT   8'h03
`define CMD_STORE_ALL   8'h11
`define CMD_VFORMAT     8'h20
`define CMD_VOUT_TARGET 8'h21
`define CMD_START_DLY   8'h60
`define CMD_STATUS      8'h78

// command data values and reset values
`define OP_ON           8'h80
`define OP_OFF          8'h00
`define VFORMAT_VAL     8'h17
`define VOUT_DEFAULT    16'h1800
`define VOUT_MIN        16'h0A00
`define VOUT_MAX        16'h1A66
`define TON_DEFAULT     10'h005
`define TON_MIN         10'h005
`define TON_MAX         10'h3E8
`define HICCUP_MS       10'h064
`define DEV_ADDR        7'h5B

// status byte bit positions
`define ST_OFF_BIT      6
`define ST_OV_BIT       5
`define ST_OC_BIT       4
`define ST_UV_BIT       3
`define ST_OT_BIT       2
`define ST_CML_BIT      1

// fault flag positions
`define FLT_UV          0
`define FLT_OC          1
`define FLT_OV          2
`define FLT_OT          3
`define FLT_CML         4

// timing
`define CLK_PERIOD_NS   25
`define TICK_TIME_NS    1000000
`define TICK_CYCLES     (`TICK_TIME_NS / `CLK_PERIOD_NS)

`endif

// ==== rtl/pmbus_ctrl_pkg.sv ====
// types shared by the command handler and the protection sequencer
package pmbus_ctrl_pkg;

  typedef enum logic [2:0] {
    BUS_IDLE = 3'b000,
    BUS_RX   = 3'b001,
    BUS_RACK = 3'b010,
    BUS_TX   = 3'b011,
    BUS_TACK = 3'b100
  } bus_state_e;

  typedef enum logic [1:0] {
    SEQ_OFF    = 2'b00,
    SEQ_DELAY  = 2'b01,
    SEQ_ON     = 2'b10,
    SEQ_HICCUP = 2'b11
  } seq_state_e;

  typedef struct packed {
    logic [1:0] scl_sync;
    logic [1:0] sda_sync;
    logic [1:0] onoff_sync;
    logic       scl_q;
    logic       sda_q;
    bus_state_e st;
    logic [3:0] bitcnt;
    logic [7:0] shreg;
    logic [2:0] byte_no;
    logic [1:0] rd_idx;
    logic       is_read;
    logic       nack;
    logic [7:0] cmd;
    logic [15:0] wdata;
    logic       sda_lvl;
    logic       sda_oe_n;
    logic [7:0] op;
    logic [15:0] vout;
    logic [15:0] ton_word;
    logic [9:0] ton_ms;
    logic [4:0] flags;
    logic       run;
    logic       store;
  } bus_s;

  typedef struct packed {
    logic [5:0] s1;
    logic [5:0] s2;
    logic [5:0] s3;
    seq_state_e st;
    logic [15:0] cnt;
    logic [9:0] ms_left;
    logic       uv_lock;
    logic       ot_lock;
    logic       pwr;
    logic [3:0] ev;
  } seq_s;

endpackage

// ==== rtl/seq_ctrl_if.sv ====
// link between the command handler and the protection sequencer
`timescale 1ns/1ps
interface seq_ctrl_if;
  logic       run_req;
  logic [9:0] ton_ms;
  logic [5:0] cmp;
  logic       pwr_on;
  logic [3:0] events;

  modport ctl (output run_req, output ton_ms, output cmp,
               input pwr_on, input events);
  modport seq (input run_req, input ton_ms, input cmp,
               output pwr_on, output events);
endinterface

// ==== rtl/protect_seq.sv ====
// start delay, undervoltage, hiccup and overtemperature sequencing
`timescale 1ns/1ps
`include "pmbus_ctrl_consts.svh"
module protect_seq
  import pmbus_ctrl_pkg::*;
#(
  parameter int TICK_CYCLES = `TICK_CYCLES
) (
  // clock and reset
  input  wire logic clk_in,
  input  wire logic reset_n_in,
  // handler link
  seq_ctrl_if.seq   ctl
);

  seq_s r_reg;
  seq_s r_next;

  ///////////////////////////////////////////////////////////////////////////
  // comparator inputs: cmp = {ot_cool, ot_high, ov, oc, vin_ok, vin_low}
  logic vin_low, vin_ok, oc, ov, ot_high, ot_cool, tick, trip, hic;
  assign vin_low = r_reg.s2[0];
  assign vin_ok  = r_reg.s2[1];
  assign oc      = r_reg.s2[2];
  assign ov      = r_reg.s2[3];
  assign ot_high = r_reg.s2[4];
  assign ot_cool = r_reg.s2[5];
  assign tick    = (r_reg.cnt == 16'(TICK_CYCLES - 1));
  assign hic     = oc | ov;

  // next state of the sequencer
  always_comb begin
    r_next    = r_reg;
    r_next.s1 = ctl.cmp;
    r_next.s2 = r_reg.s1;
    r_next.s3 = r_reg.s2;
    r_next.cnt = tick ? 16'h0000 : r_reg.cnt + 16'h0001;
    // lock held between the two thresholds gives the hysteresis
    if (vin_low) begin
      r_next.uv_lock = 1'b1;
    end else if (vin_ok) begin
      r_next.uv_lock = 1'b0;
    end
    if (ot_high) begin
      r_next.ot_lock = 1'b1;
    end else if (ot_cool) begin
      r_next.ot_lock = 1'b0;
    end
    // one-cycle event pulses for the latched flags
    r_next.ev[`FLT_UV] = r_next.uv_lock & ~r_reg.uv_lock;
    r_next.ev[`FLT_OC] = oc & ~r_reg.s3[2];
    r_next.ev[`FLT_OV] = ov & ~r_reg.s3[3];
    r_next.ev[`FLT_OT] = r_next.ot_lock & ~r_reg.ot_lock;
    trip = ~ctl.run_req | r_reg.uv_lock | r_reg.ot_lock;
    case (r_reg.st)
      SEQ_OFF: begin
        r_next.pwr = 1'b0;
        if (!trip) begin
          r_next.st      = SEQ_DELAY;
          r_next.ms_left = ctl.ton_ms;
          r_next.cnt     = 16'h0000;
        end
      end
      SEQ_DELAY: begin
        if (trip) begin
          r_next.st = SEQ_OFF;
        end else if (tick) begin
          if (r_reg.ms_left <= 10'h001) begin
            r_next.st  = SEQ_ON;
            r_next.pwr = 1'b1;
          end else begin
            r_next.ms_left = r_reg.ms_left - 10'h001;
          end
        end
      end
      SEQ_ON: begin
        if (trip) begin
          r_next.st  = SEQ_OFF;
          r_next.pwr = 1'b0;
        end else if (hic) begin
          r_next.st      = SEQ_HICCUP;
          r_next.pwr     = 1'b0;
          r_next.ms_left = `HICCUP_MS;
          r_next.cnt     = 16'h0000;
        end
      end
      SEQ_HICCUP: begin
        if (trip) begin
          r_next.st = SEQ_OFF;
        end else if (tick) begin
          if (r_reg.ms_left > 10'h001) begin
            r_next.ms_left = r_reg.ms_left - 10'h001;
          end else if (hic) begin
            r_next.ms_left = `HICCUP_MS;
          end else begin
            r_next.st      = SEQ_DELAY;
            r_next.ms_left = ctl.ton_ms;
          end
        end
      end
      default: begin
        r_next.st  = SEQ_OFF;
        r_next.pwr = 1'b0;
      end
    endcase
  end

  // state register
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      r_reg    <= '0;
      r_reg.st <= SEQ_OFF;
    end else begin
      r_reg <= r_next;
    end
  end

  assign ctl.pwr_on = r_reg.pwr;
  assign ctl.events = r_reg.ev;

endmodule

// ==== rtl/pmbus_cmd_ctrl.sv ====
// pmbus slave, command handling, fault flags and protection hookup
`timescale 1ns/1ps
`include "pmbus_ctrl_consts.svh"
module pmbus_cmd_ctrl
  import pmbus_ctrl_pkg::*;
#(
  parameter int TICK_CYCLES = `TICK_CYCLES
) (
  // clock and reset
  input  wire logic        clk_in,
  input  wire logic        reset_n_in,
  // pmbus pins
  input  wire logic        scl_in,
  input  wire logic        sda_in,
  output logic             sda_out,
  output logic             sda_oe_n_out,
  // remote on/off pin, active low
  input  wire logic        onoff_n_in,
  // protection comparators
  input  wire logic        vin_low_in,
  input  wire logic        vin_ok_in,
  input  wire logic        oc_in,
  input  wire logic        ov_in,
  input  wire logic        ot_high_in,
  input  wire logic        ot_cool_in,
  // power stage and storage
  output logic             power_enable_out,
  output logic [15:0]      vout_target_out,
  output logic             store_out
);

  bus_s r_reg;
  bus_s r_next;
  seq_ctrl_if ifc ();

  ///////////////////////////////////////////////////////////////////////////
  // helpers

  // only these codes are acked; anything else is a comm fault
  function automatic logic cmd_known(input logic [7:0] c);
    cmd_known = (c == `CMD_OPERATION) || (c == `CMD_CLEAR_FLT) ||
                (c == `CMD_STORE_ALL) || (c == `CMD_VFORMAT) ||
                (c == `CMD_VOUT_TARGET) || (c == `CMD_START_DLY) ||
                (c == `CMD_STATUS);
  endfunction

  // read data, words go low byte first
  function automatic logic [7:0] tx_byte(input bus_s s,
                                          input logic [1:0] idx,
                                          input logic off);
    logic [15:0] w;
    w = 16'hFFFF;
    case (s.cmd)
      `CMD_OPERATION:   w = {8'h00, s.op};
      `CMD_VFORMAT:     w = {8'h00, `VFORMAT_VAL};
      `CMD_VOUT_TARGET: w = s.vout;
      `CMD_START_DLY:   w = s.ton_word;
      `CMD_STATUS: begin
        w = 16'h0000;
        w[`ST_OFF_BIT] = off;
        w[`ST_OV_BIT]  = s.flags[`FLT_OV];
        w[`ST_OC_BIT]  = s.flags[`FLT_OC];
        w[`ST_UV_BIT]  = s.flags[`FLT_UV];
        w[`ST_OT_BIT]  = s.flags[`FLT_OT];
        w[`ST_CML_BIT] = s.flags[`FLT_CML];
      end
      default:          w = 16'hFFFF;
    endcase
    tx_byte = (idx == 2'b00) ? w[7:0] : ((idx == 2'b01) ? w[15:8] : 8'hFF);
  endfunction

  ///////////////////////////////////////////////////////////////////////////
  // pin edges, sampled after two flops
  logic scl, sda, scl_rise, scl_fall, start_c, stop_c;
  logic [4:0] set_f, clr_f;
  logic       commit;
  logic [4:0] n_exp;
  logic [10:0] mant;
  logic [25:0] ms_val;
  assign scl      = r_reg.scl_sync[1];
  assign sda      = r_reg.sda_sync[1];
  assign scl_rise = scl & ~r_reg.scl_q;
  assign scl_fall = ~scl & r_reg.scl_q;
  assign start_c  = scl & r_reg.scl_q & r_reg.sda_q & ~sda;
  assign stop_c   = scl & r_reg.scl_q & ~r_reg.sda_q & sda;
  assign commit   = stop_c & ~r_reg.is_read & (r_reg.st != BUS_IDLE);
  assign n_exp    = r_reg.wdata[15:11];
  assign mant     = r_reg.wdata[10:0];
  // non-negative exponent only; wide so no shift wraps back into range
  assign ms_val   = {15'h0000, mant} << n_exp[3:0];

  // bus engine and command execution
  always_comb begin
    r_next            = r_reg;
    r_next.scl_sync   = {r_reg.scl_sync[0], scl_in};
    r_next.sda_sync   = {r_reg.sda_sync[0], sda_in};
    r_next.onoff_sync = {r_reg.onoff_sync[0], onoff_n_in};
    r_next.scl_q      = scl;
    r_next.sda_q      = sda;
    r_next.store      = 1'b0;
    set_f             = {1'b0, ifc.events};
    clr_f             = 5'h00;
    if (start_c) begin
      r_next.st       = BUS_RX;
      r_next.bitcnt   = 4'h0;
      r_next.byte_no  = 3'h0;
      r_next.sda_oe_n = 1'b1;
    end else if (stop_c) begin
      r_next.st       = BUS_IDLE;
      r_next.sda_oe_n = 1'b1;
    end else begin
      case (r_reg.st)
        BUS_IDLE: r_next.sda_oe_n = 1'b1;
        BUS_RX: begin
          if (scl_rise && r_reg.bitcnt != 4'h8) begin
            r_next.shreg  = {r_reg.shreg[6:0], sda};
            r_next.bitcnt = r_reg.bitcnt + 4'h1;
          end else if (scl_fall && r_reg.bitcnt == 4'h8) begin
            r_next.st       = BUS_RACK;
            r_next.sda_oe_n = 1'b0;
            if (r_reg.byte_no != 3'h7) begin
              r_next.byte_no = r_reg.byte_no + 3'h1;
            end
            case (r_reg.byte_no)
              3'h0: begin
                r_next.is_read = r_reg.shreg[0];
                if (r_reg.shreg[7:1] != `DEV_ADDR) begin
                  r_next.st       = BUS_IDLE;
                  r_next.sda_oe_n = 1'b1;
                end
              end
              3'h1: begin
                r_next.cmd = r_reg.shreg;
                if (!cmd_known(r_reg.shreg)) begin
                  r_next.st       = BUS_IDLE; // nack unknown codes
                  r_next.sda_oe_n = 1'b1;
                  set_f[`FLT_CML] = 1'b1;
                end
              end
              3'h2: r_next.wdata[7:0]  = r_reg.shreg;
              3'h3: r_next.wdata[15:8] = r_reg.shreg;
              default: r_next.wdata = r_reg.wdata; // extra bytes ignored
            endcase
          end
        end
        BUS_RACK: begin
          if (scl_fall) begin
            r_next.bitcnt = 4'h0;
            if (r_reg.is_read && r_reg.byte_no == 3'h1) begin
              r_next.st       = BUS_TX;
              r_next.shreg    = tx_byte(r_reg, 2'b00, ~ifc.pwr_on);
              r_next.sda_oe_n = r_next.shreg[7];
              r_next.bitcnt   = 4'h1;
              r_next.rd_idx   = 2'b01;
            end else begin
              r_next.st       = BUS_RX;
              r_next.sda_oe_n = 1'b1;
            end
          end
        end
        BUS_TX: begin
          if (scl_fall) begin
            if (r_reg.bitcnt == 4'h8) begin
              r_next.st       = BUS_TACK;
              r_next.sda_oe_n = 1'b1;
            end else begin
              r_next.shreg    = {r_reg.shreg[6:0], 1'b0};
              r_next.sda_oe_n = r_reg.shreg[6];
              r_next.bitcnt   = r_reg.bitcnt + 4'h1;
            end
          end
        end
        BUS_TACK: begin
          if (scl_rise) begin
            r_next.nack = sda;
          end else if (scl_fall) begin
            if (r_reg.nack) begin
              r_next.st = BUS_IDLE;
            end else begin
              r_next.st       = BUS_TX;
              r_next.shreg    = tx_byte(r_reg, r_reg.rd_idx, ~ifc.pwr_on);
              r_next.sda_oe_n = r_next.shreg[7];
              r_next.bitcnt   = 4'h1;
              if (r_reg.rd_idx != 2'b11) begin
                r_next.rd_idx = r_reg.rd_idx + 2'b01;
              end
            end
          end
        end
        default: begin
          r_next.st       = BUS_IDLE;
          r_next.sda_oe_n = 1'b1;
        end
      endcase
    end
    // writes take effect at the stop condition
    if (commit && r_reg.byte_no == 3'h2) begin
      if (r_reg.cmd == `CMD_CLEAR_FLT) begin
        clr_f = 5'h1F;
      end
      if (r_reg.cmd == `CMD_STORE_ALL) begin
        r_next.store = 1'b1;
      end
    end
    if (commit && r_reg.byte_no == 3'h3 && r_reg.cmd == `CMD_OPERATION) begin
      if (r_reg.wdata[7:0] == `OP_ON || r_reg.wdata[7:0] == `OP_OFF) begin
        r_next.op = r_reg.wdata[7:0];
      end else begin
        set_f[`FLT_CML] = 1'b1;
      end
    end
    if (commit && r_reg.byte_no >= 3'h4) begin
      if (r_reg.cmd == `CMD_VOUT_TARGET) begin
        if (r_reg.wdata >= `VOUT_MIN && r_reg.wdata <= `VOUT_MAX) begin
          r_next.vout = r_reg.wdata;
        end else begin
          set_f[`FLT_CML] = 1'b1;
        end
      end
      if (r_reg.cmd == `CMD_START_DLY) begin
        if (!n_exp[4] && !mant[10] && n_exp[3:0] <= 4'h9 &&
            ms_val >= 26'(`TON_MIN) && ms_val <= 26'(`TON_MAX)) begin
          r_next.ton_word = r_reg.wdata;
          r_next.ton_ms   = ms_val[9:0];
        end else begin
          set_f[`FLT_CML] = 1'b1;
        end
      end
    end
    // a fault arriving during a clear stays set
    r_next.flags = (r_reg.flags & ~clr_f) | set_f;
    r_next.run   = (r_reg.op == `OP_ON) & ~r_reg.onoff_sync[1];
  end

  // state register with documented power-up defaults
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      r_reg          <= '0;
      r_reg.scl_sync <= 2'b11;
      r_reg.sda_sync <= 2'b11;
      r_reg.scl_q    <= 1'b1;
      r_reg.sda_q    <= 1'b1;
      r_reg.onoff_sync <= 2'b11;
      r_reg.st       <= BUS_IDLE;
      r_reg.sda_oe_n <= 1'b1;
      r_reg.op       <= `OP_ON;
      r_reg.vout     <= `VOUT_DEFAULT;
      r_reg.ton_word <= {6'h00, `TON_DEFAULT};
      r_reg.ton_ms   <= `TON_DEFAULT;
    end else begin
      r_reg <= r_next;
    end
  end

  ///////////////////////////////////////////////////////////////////////////
  // protection sequencer
  assign ifc.run_req = r_reg.run;
  assign ifc.ton_ms  = r_reg.ton_ms;
  assign ifc.cmp     = {ot_cool_in, ot_high_in, ov_in, oc_in,
                        vin_ok_in, vin_low_in};

  protect_seq #(
    .TICK_CYCLES (TICK_CYCLES)
  ) u_seq (
    .clk_in     (clk_in),
    .reset_n_in (reset_n_in),
    .ctl        (ifc.seq)
  );

  // outputs
  assign sda_out          = r_reg.sda_lvl;
  assign sda_oe_n_out     = r_reg.sda_oe_n;
  assign power_enable_out = ifc.pwr_on;
  assign vout_target_out  = r_reg.vout;
  assign store_out        = r_reg.store;

endmodule

// ==== verification/pmbus_host_model.sv ====
// pmbus master model standing on the host side of the bus
`timescale 1ns/1ps
module pmbus_host_model (
  // clock and bus pins
  input  wire logic clk_in,
  input  wire logic sda_in,
  output logic      scl_out,
  output logic      sda_oe_n_out
);
  // bus idles released; scl stands still between frames
  initial begin
    scl_out      = 1'b1;
    sda_oe_n_out = 1'b1;
  end

  ////////////////////////////////////////
  task automatic w(input int n);
    repeat (n) @(posedge clk_in);
  endtask

  // one bit in 8 clocks (200 ns); sda moves only while scl is low,
  // read late in the high phase since the device answers 3-4 clk late
  task automatic bit_io(input logic b, output logic r);
    w(2);
    sda_oe_n_out <= b;
    w(3);
    scl_out <= 1'b1;
    w(3);
    r = sda_in;
    scl_out <= 1'b0;
  endtask

  // start, also repeated start; waits out a trailing device ack first
  task automatic start();
    w(4);
    sda_oe_n_out <= 1'b1;
    w(2);
    scl_out <= 1'b1;
    w(4);
    sda_oe_n_out <= 1'b0;
    w(4);
    scl_out <= 1'b0;
  endtask

  task automatic stop();
    w(2);
    sda_oe_n_out <= 1'b0;
    w(3);
    scl_out <= 1'b1;
    w(4);
    sda_oe_n_out <= 1'b1;
    w(4);
  endtask

  task automatic put(input logic [7:0] b, inout logic ok);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(b[i], r);
    bit_io(1'b1, r);
    ok &= !r;
  endtask

  // write of nw bytes, or a read of nr bytes after the command
  task automatic xfer(input logic [6:0] adr, input logic [7:0] cmd,
                      input int nw, input logic [15:0] wd, input int nr,
                      output logic [15:0] rd, output logic ok);
    logic r;
    ok = 1'b1;
    rd = 16'h0000;
    start();
    put({adr, 1'b0}, ok);
    put(cmd, ok);
    for (int i = 0; i < nw; i++) put(wd[8*i +: 8], ok);
    if (nr > 0) begin
      start();
      put({adr, 1'b1}, ok);
      for (int i = 0; i < 8 * nr; i++) begin
        bit_io(1'b1, r);
        rd[8 * (i / 8) + 7 - i % 8] = r;
        if (i % 8 == 7) bit_io(i == 8 * nr - 1, r);
      end
    end
    stop();
  endtask
endmodule

// ==== verification/pmbus_cmd_checker.sv ====
// concurrent checks on the pins of the converter command block
`timescale 1ns/1ps
`include "pmbus_ctrl_consts.svh"
module pmbus_cmd_checker #(
  parameter int TICK_CYCLES = 40000
) (
  // watched pins
  input wire logic        clk_in,
  input wire logic        reset_n_in,
  input wire logic        scl_in,
  input wire logic        sda_in,
  input wire logic        sda_out,
  input wire logic        sda_oe_n_out,
  input wire logic        onoff_n_in,
  input wire logic        vin_low_in,
  input wire logic        vin_ok_in,
  input wire logic        oc_in,
  input wire logic        ov_in,
  input wire logic        ot_high_in,
  input wire logic        ot_cool_in,
  input wire logic        power_enable_out,
  input wire logic [15:0] vout_target_out,
  input wire logic        store_out
);
  logic [31:0] run_cnt;
  logic [31:0] calm_cnt;
  // clocks since the pin went low and since the last fault input
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      run_cnt  <= 32'h0;
      calm_cnt <= 32'h0;
    end else begin
      run_cnt  <= onoff_n_in ? 32'h0 : run_cnt + 32'h1;
      calm_cnt <= (vin_low_in | oc_in | ov_in | ot_high_in) ? 32'h0
                  : calm_cnt + 32'h1;
    end
  end

  ////////////////////////////////////////
  default clocking @(posedge clk_in); endclocking
  default disable iff (!reset_n_in);

  AST_PIN_OFF: assert property (onoff_n_in [*8] |-> !power_enable_out)
    else $error("output on with remote pin high");
  AST_RUN_DELAY: assert property ($rose(power_enable_out) |->
    run_cnt >= 5 * TICK_CYCLES) else $error("start delay too short");
  AST_CALM_DELAY: assert property ($rose(power_enable_out) |->
    calm_cnt >= 5 * TICK_CYCLES) else $error("restart too soon after fault");
  AST_UV_HOLD: assert property ((vin_low_in && !vin_ok_in) [*8] |->
    !power_enable_out) else $error("output on in undervoltage");
  AST_OC_OV_OFF: assert property ($rose(oc_in | ov_in) |->
    ##[1:8] !power_enable_out) else $error("no hiccup off");
  AST_OT_OFF: assert property (ot_high_in |=> ##[0:7]
    !power_enable_out) else $error("output on above temperature");
  AST_STORE_PULSE: assert property (store_out |=> !store_out)
    else $error("store pulse longer than one clock");
  AST_STORE_STOP: assert property ($rose(store_out) |->
    scl_in && $past(scl_in, 3)) else $error("store outside stop");
  AST_VOUT_RANGE: assert property (vout_target_out >= `VOUT_MIN &&
    vout_target_out <= `VOUT_MAX) else $error("vout target out of range");
  AST_VOUT_ON_STOP: assert property ($changed(vout_target_out) |->
    scl_in && $past(scl_in, 2)) else $error("vout changed mid frame");
  AST_SDA_OPEN_DRAIN: assert property (!sda_out)
    else $error("sda driven high");
  // the device may only move sda while scl is low, or it fakes a start
  AST_SDA_SCL_LOW: assert property ($changed(sda_oe_n_out) |->
    !scl_in) else $error("sda moved while scl high");
endmodule

bind pmbus_cmd_ctrl pmbus_cmd_checker #(.TICK_CYCLES(TICK_CYCLES)) chk (
  .clk_in(clk_in), .reset_n_in(reset_n_in), .scl_in(scl_in),
  .sda_in(sda_in), .sda_out(sda_out), .sda_oe_n_out(sda_oe_n_out),
  .onoff_n_in(onoff_n_in), .vin_low_in(vin_low_in),
  .vin_ok_in(vin_ok_in), .oc_in(oc_in), .ov_in(ov_in),
  .ot_high_in(ot_high_in), .ot_cool_in(ot_cool_in),
  .power_enable_out(power_enable_out),
  .vout_target_out(vout_target_out), .store_out(store_out));

// ==== verification/test_converter_pmbus_command_control.sv ====
// self-checking bench for the converter command and protection block
`timescale 1ns/1ps
`include "pmbus_ctrl_consts.svh"
module test_converter_pmbus_command_control;
  localparam int TICK = 40;
  typedef struct {
    logic [7:0]  cmd;
    int          nw;
    logic [15:0] wd;
    int          nr;
    logic [15:0] want;
    logic        ack;
  } row_s;
  logic        clk_in     = 1'b0;
  logic        reset_n_in = 1'b0;
  logic        onoff_n    = 1'b1;
  logic [3:0]  flt        = 4'h0;
  logic [1:0]  ok         = 2'b11;
  logic        scl, sda, host_oe_n, dut_sda, dut_oe_n, pwr, store, ack;
  logic [15:0] vout, rd;
  int          err_total   = 0;
  int          checks_done = 0;
  int          stores      = 0;
  // status after recovery: uv, oc, ov, ot flags still latched
  logic [15:0] st [4] = '{16'h0008, 16'h0010, 16'h0020, 16'h0004};
  row_s rows [15] = '{
    '{8'h01, 0, 16'h0000, 1, 16'h0080, 1'b1},
    '{8'h20, 0, 16'h0000, 1, 16'h0017, 1'b1},
    '{8'h21, 0, 16'h0000, 2, 16'h1800, 1'b1},
    '{8'h60, 0, 16'h0000, 2, 16'h0005, 1'b1},
    '{8'h21, 2, 16'h0A00, 0, 16'h0000, 1'b1},
    '{8'h21, 2, 16'h1A67, 0, 16'h0000, 1'b1},
    '{8'h21, 0, 16'h0000, 2, 16'h0A00, 1'b1},
    '{8'h21, 2, 16'h1A66, 0, 16'h0000, 1'b1},
    '{8'h60, 2, 16'h000A, 0, 16'h0000, 1'b1},
    '{8'h60, 2, 16'h3A01, 0, 16'h0000, 1'b1},
    '{8'h60, 0, 16'h0000, 2, 16'h000A, 1'b1},
    '{8'h55, 0, 16'h0000, 0, 16'h0000, 1'b0},
    '{8'h78, 0, 16'h0000, 1, 16'h0002, 1'b1},
    '{8'h03, 0, 16'h0000, 0, 16'h0000, 1'b1},
    '{8'h78, 0, 16'h0000, 1, 16'h0000, 1'b1}};

  // open-drain wire with pull-up
  assign sda = host_oe_n & (dut_oe_n | dut_sda);
  always #12.5 clk_in = ~clk_in;
  always @(posedge clk_in) if (store) stores <= stores + 1;

  pmbus_cmd_ctrl #(.TICK_CYCLES(TICK)) uut (
    .clk_in(clk_in), .reset_n_in(reset_n_in), .scl_in(scl),
    .sda_in(sda), .sda_out(dut_sda), .sda_oe_n_out(dut_oe_n),
    .onoff_n_in(onoff_n), .vin_low_in(flt[0]), .vin_ok_in(ok[0]),
    .oc_in(flt[1]), .ov_in(flt[2]), .ot_high_in(flt[3]),
    .ot_cool_in(ok[1]), .power_enable_out(pwr),
    .vout_target_out(vout), .store_out(store));
  pmbus_host_model host (
    .clk_in(clk_in), .sda_in(sda), .scl_out(scl),
    .sda_oe_n_out(host_oe_n));

  ////////////////////////////////////////
  task automatic chk_bit(input logic got, input logic want);
    checks_done++;
    if (got !== want) begin
      err_total++;
      $display("[ERR] %0t bit got %b want %b", $time, got, want);
    end
  endtask
  task automatic chk_word(input logic [15:0] got, input logic [15:0] want);
    checks_done++;
    if (got !== want) begin
      err_total++;
      $display("[ERR] %0t word got %h want %h", $time, got, want);
    end
  endtask
  task automatic run(input logic [7:0] c, input int nw, input int nr);
    host.xfer(`DEV_ADDR, c, nw, {8'h00, `OP_ON}, nr, rd, ack);
  endtask
  // bounded wait for the power enable to reach a level
  task automatic pwr_wait(input int n, input logic v);
    for (int i = 0; i < n && pwr !== v; i++) @(negedge clk_in);
    chk_bit(pwr, v);
  endtask
  task automatic finish_test();
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // two hiccup-length recoveries (oc, ov), two short ones (uv, ot) plus traffic fit well inside this
  initial begin
    repeat (60000) @(posedge clk_in);
    err_total++;
    finish_test();
  end

  initial begin
    repeat (10) @(negedge clk_in);
    chk_bit(dut_oe_n, 1'b1);
    chk_bit(dut_sda, 1'b0);
    chk_bit(pwr, 1'b0);
    chk_bit(store, 1'b0);
    chk_word(vout, `VOUT_DEFAULT);
    repeat (10) @(posedge clk_in);
    reset_n_in <= 1'b1;
    repeat (8 * TICK) @(negedge clk_in);
    chk_bit(pwr, 1'b0);
    @(posedge clk_in);
    onoff_n <= 1'b0;
    repeat (5 * TICK - 10) @(negedge clk_in);
    chk_bit(pwr, 1'b0);
    pwr_wait(40, 1'b1);
    foreach (rows[i]) begin
      host.xfer(`DEV_ADDR, rows[i].cmd, rows[i].nw, rows[i].wd,
                rows[i].nr, rd, ack);
      chk_bit(ack, rows[i].ack);
      if (rows[i].nr > 0) chk_word(rd, rows[i].want);
    end
    chk_word(vout, `VOUT_MAX);
    host.xfer(`DEV_ADDR, `CMD_OPERATION, 1, 16'h0000, 0, rd, ack);
    pwr_wait(20, 1'b0);
    run(`CMD_STATUS, 0, 1);
    chk_word(rd, 16'h0040);
    run(`CMD_OPERATION, 1, 0);
    repeat (10 * TICK - 20) @(negedge clk_in);
    chk_bit(pwr, 1'b0);
    pwr_wait(40, 1'b1);
    host.xfer(7'h50, `CMD_OPERATION, 1, 16'h0000, 0, rd, ack);
    chk_bit(ack, 1'b0);
    run(`CMD_STORE_ALL, 0, 0);
    repeat (20) @(negedge clk_in);
    chk_bit(pwr, 1'b1);
    chk_word(16'(stores), 16'h0001);
    // raise each fault, drop it, then let the device recover
    for (int i = 0; i < 4; i++) begin
      @(posedge clk_in);
      flt[i] <= 1'b1;
      ok <= 2'b00;
      pwr_wait(20, 1'b0);
      @(posedge clk_in);
      flt[i] <= 1'b0;
      repeat (300) @(negedge clk_in);
      chk_bit(pwr, 1'b0);
      @(posedge clk_in);
      ok <= 2'b11;
      pwr_wait(110 * TICK + 100, 1'b1);
      run(`CMD_STATUS, 0, 1);
      chk_word(rd, st[i]);
      run(`CMD_CLEAR_FLT, 0, 0);
      run(`CMD_STATUS, 0, 1);
      chk_word(rd, 16'h0000);
    end
    // mid-run reset: defaults return, start delay back to 5 ms
    @(posedge clk_in);
    reset_n_in <= 1'b0;
    repeat (4) @(posedge clk_in);
    reset_n_in <= 1'b1;
    @(negedge clk_in);
    chk_word(vout, `VOUT_DEFAULT);
    chk_bit(pwr, 1'b0);
    repeat (5 * TICK - 10) @(negedge clk_in);
    chk_bit(pwr, 1'b0);
    pwr_wait(30, 1'b1);
    finish_test();
  end
endmodule
